// ### core/ldgc_pkg.sv
/*
 * Package for the LED drive and gain control register bank.
 * It holds the register offsets, field positions, reset values and encodings.
 * It assumes an 8-bit register port with one address per register.
 */
package ldgc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_RED_STOP = 8'h00;
    localparam logic [7:0] OFS_GREEN_STOP = 8'h01;
    localparam logic [7:0] OFS_BLUE_STOP = 8'h02;
    localparam logic [7:0] OFS_BEGIN_LOW = 8'h03;
    localparam logic [7:0] OFS_RED_GAIN = 8'h04;
    localparam logic [7:0] OFS_GREEN_GAIN = 8'h05;
    localparam logic [7:0] OFS_BLUE_GAIN = 8'h06;
    localparam logic [7:0] OFS_ALL_GAIN = 8'h07;
    localparam logic [7:0] OFS_BLANK_LIMIT = 8'h08;
    localparam logic [7:0] OFS_TIMING_RESET = 8'h09;
    localparam logic [7:0] OFS_LIMIT_FLAGS = 8'h0A;
    localparam logic [7:0] OFS_TEST_CTRL = 8'h0B;
    localparam logic [7:0] OFS_REVISION = 8'h0C;
    localparam logic [7:0] OFS_MODE_CTRL = 8'h0D;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int STOP_MSB = 6;
    localparam int BEGIN_BIT = 7;
    localparam int BEGIN_LOW_LSB = 4;
    localparam int BLANK_MSB = 5;
    localparam int REDUCE_BIT = 6;
    localparam int HIT_BIT = 7;
    localparam int FLAG_BLUE = 0;
    localparam int FLAG_GREEN = 1;
    localparam int FLAG_RED = 2;
    localparam int TEST_LSB = 2;
    localparam int TEST_MSB = 5;
    localparam int MODE_INTERLEAVE_LSB = 0;
    localparam int MODE_BEGIN_REQ = 3;
    localparam int MODE_LIMIT_LSB = 6;
    localparam int REV_LSB = 1;
    localparam int BLANK_ZERO_BITS = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_STOP = 8'h10;
    localparam logic [3:0] RST_BEGIN_LOW = 4'h0;
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [5:0] RST_BLANK = 6'h00;
    localparam logic [3:0] RST_TEST = 4'h0;
    localparam logic [1:0] RST_LIMIT_MODE = 2'h0;
    localparam logic [1:0] RST_INTERLEAVE = 2'h0;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [1:0] OVR_NONE = 2'h0;
    localparam logic [1:0] OVR_LOAD = 2'h1;
    localparam logic [1:0] OVR_CHECK = 2'h2;
    localparam logic [1:0] OVR_ON = 2'h3;
    localparam logic [1:0] COL_RED = 2'h0;
    localparam logic [1:0] COL_GREEN = 2'h1;
    localparam logic [1:0] COL_BLUE = 2'h2;
    localparam logic [1:0] LIMIT_OFF = 2'h0;
    // Interleave select: follow colour, or fix one gain
    localparam logic [1:0] INTL_FOLLOW = 2'h0;
    localparam logic [1:0] INTL_RED = 2'h1;
    localparam logic [1:0] INTL_GREEN = 2'h2;
    localparam logic [1:0] INTL_BLUE = 2'h3;

endpackage : ldgc_pkg

// ### core/ldgc_regs.sv
/*
 * LED drive and gain control register bank.
 * Holds stop and begin times, gain codes, blank time, current limit flags,
 * the timing reset strobe, current DAC test overrides and the revision.
 * Assumes a single-cycle register port on ref_clk and limit-hit and begin
 * pins that are asynchronous to ref_clk.
 */
// Strobed register access and the address map were decided locally.
module ldgc_regs #(
    // Revision value is arbitrary
    parameter logic [6:0] REVISION = 7'h01
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWe,
    input wire logic regRe,
    output logic [7:0] regRdata,
    // Timing outputs
    output logic [6:0] red_stop_time,
    output logic [6:0] green_stop_time,
    output logic [6:0] blue_stop_time,
    output logic [6:0] led_begin_time,
    output logic begin_time_request,
    output logic [8:0] initial_blank_time,
    output logic ledTimingReset,
    // Gain
    input wire logic [1:0] activeColour,
    output logic [7:0] selectedGain,
    // Current limit pins and controls
    input wire logic redLimitPin,
    input wire logic greenLimitPin,
    input wire logic blueLimitPin,
    output logic reduceEighth,
    output logic reduceQuarter,
    // Current DAC control
    input wire logic stateInReset,
    output logic current_dac_force_load,
    output logic setupChange,
    output logic current_dac_off_signal,
    output logic current_dac_force_check,
    output logic colourSwitchEnable,
    output logic current_dac_cal_signal,
    output logic current_dac_force_on,
    output logic currentReload,
    output logic reloadFromRed,
    // LED on drive
    input wire logic counterLedOn,
    input wire logic ledBeginPin,
    output logic led_on_drive
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] redStop;
        logic [7:0] greenStop;
        logic [7:0] blueStop;
        logic [3:0] beginLow;
        logic [7:0] red_gain_code;
        logic [7:0] green_gain_code;
        logic [7:0] blue_gain_code;
        logic [5:0] blankField;
        logic limit_reduction_select;
        logic red_limit_hit;
        logic green_limit_hit;
        logic blue_limit_hit;
        logic [3:0] led_test_field;
        logic [1:0] interleave_select;
        logic beginRequest;
        logic [1:0] current_limit_mode;
        logic [7:0] rdata;
        logic [7:0] gainOut;
        logic ledOn;
        logic timingRst;
    } ldgc_state_t;

    ldgc_state_t state_q;
    ldgc_state_t state_d;

    logic [2:0] limitSync;
    logic beginSync;
    logic limitActive;
    logic current_limit_hit;
    logic [1:0] overrideMode;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    ldgc_sync #(
        .WIDTH(3)
    ) u_limit_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn({redLimitPin, greenLimitPin, blueLimitPin}),
        .syncOut(limitSync)
    );

    ldgc_sync #(
        .WIDTH(1)
    ) u_begin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn(ledBeginPin),
        .syncOut(beginSync)
    );

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic isWrite(input logic [7:0] ofs);
        isWrite = regWe && (regAddr == ofs);
    endfunction : isWrite

    function automatic logic [7:0] gainFor(
        input logic [1:0] colour,
        input ldgc_state_t s
    );
        case (colour)
            ldgc_pkg::COL_RED: gainFor = s.red_gain_code;
            ldgc_pkg::COL_GREEN: gainFor = s.green_gain_code;
            ldgc_pkg::COL_BLUE: gainFor = s.blue_gain_code;
            default: gainFor = 8'h00;
        endcase
    endfunction : gainFor

    assign limitActive = (state_q.current_limit_mode != ldgc_pkg::LIMIT_OFF);
    assign current_limit_hit = state_q.red_limit_hit | state_q.green_limit_hit
        | state_q.blue_limit_hit;
    assign overrideMode = state_q.led_test_field[1:0];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_d = state_q;
        state_d.rdata = 8'h00;
        state_d.timingRst = 1'b0;

        // Writes
        if (regWe) begin
            case (regAddr)
                ldgc_pkg::OFS_RED_STOP: begin
                    state_d.redStop = regWdata;
                end
                ldgc_pkg::OFS_GREEN_STOP: begin
                    state_d.greenStop = regWdata;
                end
                ldgc_pkg::OFS_BLUE_STOP: begin
                    state_d.blueStop = regWdata;
                end
                ldgc_pkg::OFS_BEGIN_LOW: begin
                    state_d.beginLow = regWdata[7:ldgc_pkg::BEGIN_LOW_LSB];
                end
                ldgc_pkg::OFS_RED_GAIN: begin
                    state_d.red_gain_code = regWdata;
                end
                ldgc_pkg::OFS_GREEN_GAIN: begin
                    state_d.green_gain_code = regWdata;
                end
                ldgc_pkg::OFS_BLUE_GAIN: begin
                    state_d.blue_gain_code = regWdata;
                end
                ldgc_pkg::OFS_ALL_GAIN: begin
                    state_d.red_gain_code = regWdata;
                    state_d.green_gain_code = regWdata;
                    state_d.blue_gain_code = regWdata;
                end
                // blank field, hit bit not writable
                ldgc_pkg::OFS_BLANK_LIMIT: begin
                    state_d.blankField = regWdata[ldgc_pkg::BLANK_MSB:0];
                    state_d.limit_reduction_select = regWdata[ldgc_pkg::REDUCE_BIT];
                end
                ldgc_pkg::OFS_TIMING_RESET: begin
                    state_d.timingRst = 1'b1;
                end
                ldgc_pkg::OFS_TEST_CTRL: begin
                    state_d.led_test_field = regWdata[ldgc_pkg::TEST_MSB:ldgc_pkg::TEST_LSB];
                end
                ldgc_pkg::OFS_MODE_CTRL: begin
                    state_d.interleave_select =
                        regWdata[ldgc_pkg::MODE_INTERLEAVE_LSB +: 2];
                    state_d.beginRequest = regWdata[ldgc_pkg::MODE_BEGIN_REQ];
                    state_d.current_limit_mode = regWdata[ldgc_pkg::MODE_LIMIT_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // sticky flags, timing reset clears, set wins
        if (isWrite(ldgc_pkg::OFS_TIMING_RESET)) begin
            state_d.red_limit_hit = 1'b0;
            state_d.green_limit_hit = 1'b0;
            state_d.blue_limit_hit = 1'b0;
        end
        // no new flags while limiting is off; flags already set are kept
        if (limitActive) begin
            if (limitSync[2]) begin
                state_d.red_limit_hit = 1'b1;
            end
            if (limitSync[1]) begin
                state_d.green_limit_hit = 1'b1;
            end
            if (limitSync[0]) begin
                state_d.blue_limit_hit = 1'b1;
            end
        end

        // Reads
        if (regRe) begin
            case (regAddr)
                ldgc_pkg::OFS_RED_STOP: state_d.rdata = state_q.redStop;
                ldgc_pkg::OFS_GREEN_STOP: state_d.rdata = state_q.greenStop;
                ldgc_pkg::OFS_BLUE_STOP: state_d.rdata = state_q.blueStop;
                ldgc_pkg::OFS_BEGIN_LOW: begin
                    state_d.rdata = {state_q.beginLow, 4'h0};
                end
                ldgc_pkg::OFS_RED_GAIN: state_d.rdata = state_q.red_gain_code;
                ldgc_pkg::OFS_GREEN_GAIN: state_d.rdata = state_q.green_gain_code;
                ldgc_pkg::OFS_BLUE_GAIN: state_d.rdata = state_q.blue_gain_code;
                ldgc_pkg::OFS_BLANK_LIMIT: begin
                    state_d.rdata = {current_limit_hit & limitActive,
                        state_q.limit_reduction_select, state_q.blankField};
                end
                ldgc_pkg::OFS_LIMIT_FLAGS: begin
                    state_d.rdata = {5'h00, state_q.red_limit_hit,
                        state_q.green_limit_hit, state_q.blue_limit_hit};
                end
                ldgc_pkg::OFS_TEST_CTRL: begin
                    state_d.rdata = {2'h0, state_q.led_test_field, 2'h0};
                end
                ldgc_pkg::OFS_REVISION: state_d.rdata = {REVISION, 1'b0};
                ldgc_pkg::OFS_MODE_CTRL: begin
                    state_d.rdata = {state_q.current_limit_mode, 2'h0,
                        state_q.beginRequest, 1'b0, state_q.interleave_select};
                end
                default: state_d.rdata = 8'h00;
            endcase
        end

        case (state_q.interleave_select)
            ldgc_pkg::INTL_FOLLOW: state_d.gainOut = gainFor(activeColour, state_q);
            ldgc_pkg::INTL_RED: state_d.gainOut = state_q.red_gain_code;
            ldgc_pkg::INTL_GREEN: state_d.gainOut = state_q.green_gain_code;
            ldgc_pkg::INTL_BLUE: state_d.gainOut = state_q.blue_gain_code;
            default: state_d.gainOut = 8'h00;
        endcase

        state_d.ledOn = state_q.led_test_field[3] ? beginSync : counterLedOn;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
            state_q.redStop <= ldgc_pkg::RST_STOP;
            state_q.greenStop <= ldgc_pkg::RST_STOP;
            state_q.blueStop <= ldgc_pkg::RST_STOP;
            state_q.beginLow <= ldgc_pkg::RST_BEGIN_LOW;
            state_q.red_gain_code <= ldgc_pkg::RST_GAIN;
            state_q.green_gain_code <= ldgc_pkg::RST_GAIN;
            state_q.blue_gain_code <= ldgc_pkg::RST_GAIN;
            state_q.blankField <= ldgc_pkg::RST_BLANK;
            state_q.led_test_field <= ldgc_pkg::RST_TEST;
            state_q.current_limit_mode <= ldgc_pkg::RST_LIMIT_MODE;
            state_q.interleave_select <= ldgc_pkg::RST_INTERLEAVE;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign regRdata = state_q.rdata;
    assign red_stop_time = state_q.redStop[ldgc_pkg::STOP_MSB:0];
    assign green_stop_time = state_q.greenStop[ldgc_pkg::STOP_MSB:0];
    assign blue_stop_time = state_q.blueStop[ldgc_pkg::STOP_MSB:0];
    assign led_begin_time = {state_q.blueStop[ldgc_pkg::BEGIN_BIT],
        state_q.greenStop[ldgc_pkg::BEGIN_BIT],
        state_q.redStop[ldgc_pkg::BEGIN_BIT], state_q.beginLow};
    assign begin_time_request = state_q.beginRequest;
    assign initial_blank_time = {state_q.blankField, {ldgc_pkg::BLANK_ZERO_BITS{1'b0}}};
    assign ledTimingReset = state_q.timingRst;
    assign selectedGain = state_q.gainOut;

    assign reduceEighth = limitActive & current_limit_hit & ~state_q.limit_reduction_select;
    assign reduceQuarter = limitActive & current_limit_hit & state_q.limit_reduction_select;

    assign current_dac_force_load = (overrideMode == ldgc_pkg::OVR_LOAD);
    assign setupChange = current_dac_force_load;
    assign current_dac_off_signal = current_dac_force_load;
    assign current_dac_force_check = (overrideMode == ldgc_pkg::OVR_CHECK);
    assign colourSwitchEnable = current_dac_force_check;
    assign current_dac_cal_signal = current_dac_force_check;
    assign current_dac_force_on = (overrideMode == ldgc_pkg::OVR_ON);
    assign currentReload = state_q.led_test_field[2];
    assign reloadFromRed = state_q.led_test_field[2] & stateInReset;

    assign led_on_drive = state_q.ledOn;

endmodule : ldgc_regs

// ### core/ldgc_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * It assumes the inputs are asynchronous levels held longer than a cycle.
 */
module ldgc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } ldgc_sync_state_t;

    ldgc_sync_state_t state_q;
    ldgc_sync_state_t state_d;

    always_comb begin
        state_d = state_q;
        state_d.stage1 = asyncIn;
        state_d.stage2 = state_q.stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stage2;

endmodule : ldgc_sync

// ### sim/ldgc_regs_sva.sv
/*
 * Checker for the LED drive and gain control register bank.
 * Assumes it is bound to ldgc_regs and sees only its ports.
 */
module ldgc_regs_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWe,
    input wire logic regRe,
    input wire logic [7:0] regRdata,
    // Watched outputs and the stateInReset input
    input wire logic [6:0] red_stop_time,
    input wire logic [6:0] led_begin_time,
    input wire logic [8:0] initial_blank_time,
    input wire logic ledTimingReset,
    input wire logic reduceEighth,
    input wire logic reduceQuarter,
    input wire logic stateInReset,
    input wire logic current_dac_force_load,
    input wire logic setupChange,
    input wire logic current_dac_off_signal,
    input wire logic current_dac_force_check,
    input wire logic colourSwitchEnable,
    input wire logic current_dac_cal_signal,
    input wire logic current_dac_force_on,
    input wire logic currentReload,
    input wire logic reloadFromRed
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ************************************************************
    // Assertions
    // ************************************************************
    a_stop_write: assert property (
        regWe && regAddr == ldgc_pkg::OFS_RED_STOP |=> red_stop_time == $past(regWdata[6:0]))
        else $error("red stop time not loaded");
    a_stop_hold: assert property (
        !(regWe && regAddr == ldgc_pkg::OFS_RED_STOP) |=> $stable(red_stop_time))
        else $error("red stop time changed without write");
    a_begin_msb: assert property (
        regWe && regAddr == ldgc_pkg::OFS_BLUE_STOP |=> led_begin_time[6] == $past(regWdata[7]))
        else $error("begin time msb wrong");
    a_blank_write: assert property (
        regWe && regAddr == ldgc_pkg::OFS_BLANK_LIMIT
        |=> initial_blank_time == {$past(regWdata[5:0]), 3'h0})
        else $error("blank time wrong");
    a_reset_pulse: assert property (
        regWe && regAddr == ldgc_pkg::OFS_TIMING_RESET
        ##1 !(regWe && regAddr == ldgc_pkg::OFS_TIMING_RESET)
        |-> ledTimingReset ##1 !ledTimingReset)
        else $error("timing reset pulse missing");
    a_reset_cause: assert property (
        $rose(ledTimingReset) |-> $past(regWe) && $past(regAddr) == ldgc_pkg::OFS_TIMING_RESET)
        else $error("timing reset without write");
    a_read_quiet: assert property (
        !$past(regRe) |-> regRdata == 8'h00)
        else $error("read data outside read cycle");
    a_reduce_excl: assert property (
        !(reduceEighth && reduceQuarter))
        else $error("both reductions active");
    a_ovr_load: assert property (
        current_dac_force_load |-> setupChange && current_dac_off_signal
        && !current_dac_force_check && !current_dac_force_on)
        else $error("load override outputs wrong");
    a_ovr_check: assert property (
        current_dac_force_check |-> colourSwitchEnable && current_dac_cal_signal
        && !current_dac_force_load && !setupChange)
        else $error("check override outputs wrong");
    a_ovr_on: assert property (
        current_dac_force_on |-> !current_dac_force_load && !current_dac_cal_signal)
        else $error("on override outputs wrong");
    a_reload_red: assert property (
        reloadFromRed == (currentReload && stateInReset))
        else $error("red reload select wrong");
endmodule : ldgc_regs_sva

bind ldgc_regs ldgc_regs_sva u_sva (.ref_clk, .rst_n, .regAddr, .regWdata, .regWe, .regRe,
    .regRdata, .red_stop_time, .led_begin_time, .initial_blank_time, .ledTimingReset,
    .reduceEighth, .reduceQuarter, .stateInReset, .current_dac_force_load, .setupChange,
    .current_dac_off_signal, .current_dac_force_check, .colourSwitchEnable,
    .current_dac_cal_signal, .current_dac_force_on, .currentReload, .reloadFromRed);

// ### sim/ldgc_regs_test.sv
/*
 * Self-checking bench for the LED drive and gain control register bank.
 * Assumes the package and design are compiled first.
 */
module ldgc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    // Revision value is arbitrary
    localparam logic [6:0] REV = 7'h2A;
    logic ref_clk, rst_n, regWe, regRe, begin_time_request, ledTimingReset;
    logic [7:0] regAddr, regWdata, regRdata, selectedGain;
    logic [6:0] red_stop_time, green_stop_time, blue_stop_time, led_begin_time;
    logic [8:0] initial_blank_time;
    logic [1:0] activeColour;
    logic redLimitPin, greenLimitPin, blueLimitPin, reduceEighth, reduceQuarter;
    logic stateInReset, current_dac_force_load, setupChange, current_dac_off_signal;
    logic current_dac_force_check, colourSwitchEnable, current_dac_cal_signal;
    logic current_dac_force_on, currentReload, reloadFromRed;
    logic counterLedOn, ledBeginPin, led_on_drive;
    int failCount = 0;
    int comparisons = 0;
    logic [7:0] rstVals [14] = '{8'h10, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, {REV, 1'b0}, 8'h00};
    logic [8:0] ovrVals [4] = '{9'h000, 9'h070, 9'h00E, 9'h001};
    logic [7:0] gainVals [4] = '{8'h33, 8'h5A, 8'h33, 8'h5A};

    ldgc_regs #(.REVISION(REV)) DUT (.ref_clk, .rst_n, .regAddr, .regWdata, .regWe, .regRe,
        .regRdata, .red_stop_time, .green_stop_time, .blue_stop_time, .led_begin_time,
        .begin_time_request, .initial_blank_time, .ledTimingReset, .activeColour,
        .selectedGain, .redLimitPin, .greenLimitPin, .blueLimitPin, .reduceEighth,
        .reduceQuarter, .stateInReset, .current_dac_force_load, .setupChange,
        .current_dac_off_signal, .current_dac_force_check, .colourSwitchEnable,
        .current_dac_cal_signal, .current_dac_force_on, .currentReload, .reloadFromRed,
        .counterLedOn, .ledBeginPin, .led_on_drive);

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic giveVerdict();
        if (failCount == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : giveVerdict

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWe <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regRe <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRe <= 1'b0;
        @(negedge ref_clk);
        chk({1'b0, regRdata}, {1'b0, exp});
    endtask : rd

    // ************************************************************
    // Stimulus
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        failCount++;
        giveVerdict();
    end

    initial begin
        {rst_n, regWe, regRe, regAddr, regWdata, activeColour} = '0;
        {redLimitPin, greenLimitPin, blueLimitPin, stateInReset} = '0;
        {counterLedOn, ledBeginPin} = '0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 14; i++) rd(8'(i), rstVals[i]);
        rd(8'h3F, 8'h00);
        wr(ldgc_pkg::OFS_RED_STOP, 8'h85);
        wr(ldgc_pkg::OFS_GREEN_STOP, 8'h03);
        wr(ldgc_pkg::OFS_BLUE_STOP, 8'hFF);
        wr(ldgc_pkg::OFS_BEGIN_LOW, 8'hA0);
        settle(0);
        chk(9'(led_begin_time), 9'h05A);
        chk(9'(blue_stop_time), 9'h07F);
        chk(9'({red_stop_time, 2'h0}) ^ 9'(green_stop_time), 9'h017);
        rd(ldgc_pkg::OFS_RED_STOP, 8'h85);
        wr(ldgc_pkg::OFS_ALL_GAIN, 8'h5A);
        for (int i = 4; i < 7; i++) rd(8'(i), 8'h5A);
        rd(ldgc_pkg::OFS_ALL_GAIN, 8'h00);
        wr(ldgc_pkg::OFS_GREEN_GAIN, 8'h33);
        activeColour <= ldgc_pkg::COL_GREEN;
        // Begin request set while each interleave select picks the gain
        for (int i = 0; i < 4; i++) begin
            wr(ldgc_pkg::OFS_MODE_CTRL, 8'(8'h08 | i));
            settle(2);
            chk({begin_time_request, selectedGain}, {1'b1, gainVals[i]});
        end
        wr(ldgc_pkg::OFS_BLANK_LIMIT, 8'hBF);
        rd(ldgc_pkg::OFS_BLANK_LIMIT, 8'h3F);
        chk(initial_blank_time, 9'h1F8);
        wr(ldgc_pkg::OFS_MODE_CTRL, 8'h00);
        redLimitPin <= 1'b1;
        settle(5);
        chk(9'({reduceEighth, reduceQuarter}), 9'h000);
        rd(ldgc_pkg::OFS_LIMIT_FLAGS, 8'h00);
        redLimitPin <= 1'b0;
        wr(ldgc_pkg::OFS_MODE_CTRL, 8'h40);
        settle(3);
        blueLimitPin <= 1'b1;
        settle(5);
        rd(ldgc_pkg::OFS_LIMIT_FLAGS, 8'h01);
        rd(ldgc_pkg::OFS_BLANK_LIMIT, 8'hBF);
        chk(9'({reduceEighth, reduceQuarter}), 9'h002);
        wr(ldgc_pkg::OFS_BLANK_LIMIT, 8'h7F);
        settle(0);
        chk(9'({reduceEighth, reduceQuarter}), 9'h001);
        {blueLimitPin, greenLimitPin, redLimitPin} <= 3'h3;
        settle(5);
        {greenLimitPin, redLimitPin} <= 2'h0;
        rd(ldgc_pkg::OFS_LIMIT_FLAGS, 8'h07);
        wr(ldgc_pkg::OFS_LIMIT_FLAGS, 8'h00);
        rd(ldgc_pkg::OFS_LIMIT_FLAGS, 8'h07);
        settle(5);
        wr(ldgc_pkg::OFS_TIMING_RESET, 8'hFF);
        settle(0);
        chk(9'(ledTimingReset), 9'h001);
        rd(ldgc_pkg::OFS_LIMIT_FLAGS, 8'h00);
        rd(ldgc_pkg::OFS_TIMING_RESET, 8'h00);
        rd(ldgc_pkg::OFS_RED_STOP, 8'h85);
        // Reserved test bits stay zero in every write
        for (int i = 0; i < 4; i++) begin
            wr(ldgc_pkg::OFS_TEST_CTRL, 8'(i << 2));
            settle(0);
            chk({2'h0, current_dac_force_load, setupChange, current_dac_off_signal,
                current_dac_force_check, colourSwitchEnable, current_dac_cal_signal,
                current_dac_force_on}, ovrVals[i]);
        end
        stateInReset <= 1'b1;
        wr(ldgc_pkg::OFS_TEST_CTRL, 8'h10);
        settle(0);
        chk(9'({currentReload, reloadFromRed}), 9'h003);
        ledBeginPin <= 1'b1;
        wr(ldgc_pkg::OFS_TEST_CTRL, 8'h3C);
        settle(5);
        chk(9'(led_on_drive), 9'h001);
        rd(ldgc_pkg::OFS_TEST_CTRL, 8'h3C);
        wr(ldgc_pkg::OFS_TEST_CTRL, 8'h00);
        settle(2);
        chk(9'(led_on_drive), 9'h000);
        counterLedOn <= 1'b1;
        settle(2);
        chk(9'(led_on_drive), 9'h001);
        giveVerdict();
    end
endmodule : ldgc_regs_test
